// ### inc/debp_pkg.sv
// shared constants and types for the external bus port
package debp_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 48;
    localparam int BANKS  = 4;
    // lane boundaries
    localparam int W32_HI = 47;
    localparam int W32_LO = 16;
    localparam int W40_LO = 8;
    localparam int W16_HI = 31;
    localparam int W8_HI  = 23;
    // processor id field in the address and multiprocessor space limit
    localparam int ID_LO  = 20;
    localparam int ID_W   = 3;
    localparam int MP_TOP = 23;
    localparam logic [ID_W-1:0] ID_NONE = 3'h0;
    // bank size code: bank n spans 2^(BANK_BASE+code) words from BANK_START
    localparam int BANK_BASE = 13;
    localparam logic [ADDR_W-1:0] BANK_START = 32'h0040_0000;
    localparam int PAGE_BASE = 8;
    localparam int MEM_DEPTH = 64;
    localparam int MEM_AW    = 6;
    localparam int FAR_HOLD  = 6; // covers slave strobe sync and read turnaround
    typedef enum logic [2:0] {
        DEBP_FMT_W32 = 3'h0,
        DEBP_FMT_W40 = 3'h1,
        DEBP_FMT_W16 = 3'h2,
        DEBP_FMT_W8  = 3'h3
    } debp_fmt_t;
    typedef enum logic [1:0] {
        DEBP_M_IDLE  = 2'h0,
        DEBP_M_ADDR  = 2'h1,
        DEBP_M_STROBE = 2'h2
    } debp_mstate_t;

    // place a word into its data lanes
    function automatic logic [DATA_W-1:0] debp_pack(input debp_fmt_t f,
                                                    input logic [39:0] w);
        logic [DATA_W-1:0] d;
        d = '0;
        unique case (f)
            DEBP_FMT_W32: d[W32_HI:W32_LO] = w[31:0];
            DEBP_FMT_W40: d[W32_HI:W40_LO] = w;
            DEBP_FMT_W16: d[W16_HI:W32_LO] = w[15:0];
            DEBP_FMT_W8:  d[W8_HI:W32_LO]  = w[7:0];
            default:      d = '0;
        endcase
        return d;
    endfunction

    // take a word from its data lanes
    function automatic logic [39:0] debp_unpack(input debp_fmt_t f,
                                                input logic [DATA_W-1:0] d);
        logic [39:0] w;
        w = '0;
        unique case (f)
            DEBP_FMT_W32: w[31:0] = d[W32_HI:W32_LO];
            DEBP_FMT_W40: w       = d[W32_HI:W40_LO];
            DEBP_FMT_W16: w[15:0] = d[W16_HI:W32_LO];
            DEBP_FMT_W8:  w[7:0]  = d[W8_HI:W32_LO];
            default:      w = '0;
        endcase
        return w;
    endfunction
endpackage

// ### inc/debp_if.sv
// shared external bus wires between port and outside party
`timescale 1ns/1ps
interface debp_if;
    import debp_pkg::*;
    logic [ADDR_W-1:0] dev_addr;
    logic              dev_addr_oe;
    logic [ADDR_W-1:0] far_addr;
    logic              far_addr_oe;
    logic [DATA_W-1:0] dev_data;
    logic              dev_data_oe;
    logic [DATA_W-1:0] far_data;
    logic              far_data_oe;
    logic              dev_rd_n;
    logic              dev_wr_n;
    logic              dev_sw_n;
    logic              dev_strobe_oe;
    logic              far_rd_n;
    logic              far_wr_n;
    logic              far_sw_n;
    logic              far_strobe_oe;
    logic [BANKS-1:0]  bank_select_n;
    logic              page;
    logic              dev_ctl_oe;
    logic              ack;
    logic              ack_oe;
    logic              bus_tristate_request_n;
    logic [ADDR_W-1:0] ext_address_bus;
    logic [DATA_W-1:0] ext_data_bus;
    logic              rd_n;
    logic              wr_n;
    logic              sync_write_select_n;
    // resolved wire levels; undriven strobes float high through pull-ups
    assign ext_address_bus = dev_addr_oe ? dev_addr : (far_addr_oe ? far_addr : '0);
    assign ext_data_bus = dev_data_oe ? dev_data : (far_data_oe ? far_data : '0);
    assign rd_n = dev_strobe_oe ? dev_rd_n : (far_strobe_oe ? far_rd_n : 1'b1);
    assign wr_n = dev_strobe_oe ? dev_wr_n : (far_strobe_oe ? far_wr_n : 1'b1);
    assign sync_write_select_n = dev_strobe_oe ? dev_sw_n
                               : (far_strobe_oe ? far_sw_n : 1'b1);
    modport dev (output dev_addr, dev_addr_oe, dev_data, dev_data_oe, dev_rd_n, dev_wr_n,
                 dev_sw_n, dev_strobe_oe, bank_select_n, page, dev_ctl_oe, ack, ack_oe,
                 input ext_address_bus, ext_data_bus, rd_n, wr_n, sync_write_select_n,
                 bus_tristate_request_n);
    modport far (output far_addr, far_addr_oe, far_data, far_data_oe, far_rd_n, far_wr_n,
                 far_sw_n, far_strobe_oe, bus_tristate_request_n,
                 input ext_address_bus, ext_data_bus, rd_n, wr_n, sync_write_select_n,
                 ack, ack_oe, bank_select_n, page);
endinterface

// ### logic/debp_device.sv
// device end of the external bus port: master sequencer and slave responder
`timescale 1ns/1ps
//
// Overview of operation
// R1 - master drives address; slave samples it
// R2 - 32-bit words on lanes 47..16
// R3 - 40-bit words on lanes 47..8
// R4 - 16-bit words on lanes 31..16
// R5 - boot bytes on lanes 23..16
// R6 - four low bank selects decoded from address
// R7 - selects idle without access; conditional still selects
// R8 - bank size from config register decodes selects
// R9 - read strobe low on reads, both directions; device as master only when its condition holds
// R10 - write strobe low on writes, both directions; device as master only when its condition holds
// R11 - only master drives strobes and sync select
// R12 - page flag on bank 0 page crossing
// R13 - sync select warns; write dropped without strobe
// R14 - sync select together with address
// R15 - slave tells read from write by sync select
// R16 - outputs released on tristate request or slave; code releases them on tristate request only, slave mode does not release them
// R17 - ack on own id match, unconditionally
// R18 - ack released every cycle after driving
// R19 - slave samples on edge, drives data next
module debp_device
    import debp_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    debp_if.dev                    bus,
    input  wire logic [ID_W-1:0]   proc_id_in,
    input  wire logic [1:0]        bank_size_in,
    input  wire logic [1:0]        page_size_in,
    input  wire logic              mp_space_wait_state_en_in,
    input  wire logic              req_in,
    input  wire logic              req_write_in,
    input  wire logic              req_cond_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire debp_pkg::debp_fmt_t req_fmt_in,
    input  wire logic [39:0]       req_wdata_in,
    output logic                   busy_out,
    output logic                   done_out,
    output logic [39:0]            rdata_out,
    output logic                   slave_write_out,
    output logic [MEM_AW-1:0]      slave_index_out
);
    import debp_pkg::*;

    // ============================================================
    // input synchronisers: three stages, change taken when 2 and 3 agree
    logic [2:0] tsr_s;
    logic [2:0] rd_s;
    logic [2:0] wr_s;
    logic       tsr_q;
    logic       rd_q;
    logic       wr_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tsr_s <= 3'h7;
            rd_s  <= 3'h7;
            wr_s  <= 3'h7;
            tsr_q <= 1'b1;
            rd_q  <= 1'b1;
            wr_q  <= 1'b1;
        end else begin
            tsr_s <= {tsr_s[1:0], bus.bus_tristate_request_n};
            rd_s  <= {rd_s[1:0], bus.rd_n};
            wr_s  <= {wr_s[1:0], bus.wr_n};
            if (tsr_s[1] == tsr_s[2]) tsr_q <= tsr_s[2];
            if (rd_s[1] == rd_s[2]) rd_q <= rd_s[2];
            if (wr_s[1] == wr_s[2]) wr_q <= wr_s[2];
        end
    end

    // ============================================================
    // configuration: bank size steers select decode
    function automatic logic [BANKS-1:0] bank_decode(input logic [ADDR_W-1:0] a,
                                                     input logic [1:0] sz);
        logic [ADDR_W-1:0] off;
        logic [ADDR_W-1:0] idx;
        logic [BANKS-1:0]  sel;
        off = a - BANK_START;
        idx = off >> (BANK_BASE + int'(sz));
        sel = '1;
        if (a >= BANK_START && idx < BANKS) sel[idx[1:0]] = 1'b0; // R8
        return sel;
    endfunction

    // ============================================================
    // master sequencer
    debp_mstate_t      mstate;
    logic [ADDR_W-1:0] m_addr;
    logic              m_write;
    logic              m_cond;
    debp_fmt_t         m_fmt;
    logic [39:0]       m_wdata;
    logic [ADDR_W-1:0] last_page;
    logic              last_page_ok;
    logic              page_cross;
    logic              slave_mode;
    logic              drive_en;
    logic [BANKS-1:0]  req_sel;
    assign req_sel = bank_decode(req_addr_in, bank_size_in); // R8
    assign slave_mode = (bus.ext_address_bus[ID_LO +: ID_W] != ID_NONE) && !bus.dev_addr_oe;
    assign drive_en = tsr_q && (mstate != DEBP_M_IDLE); // R16
    assign page_cross = !last_page_ok ||
        ((req_addr_in >> (PAGE_BASE + int'(page_size_in))) != last_page);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mstate  <= DEBP_M_IDLE;
            m_addr  <= '0;
            m_write <= 1'b0;
            m_cond  <= 1'b0;
            m_fmt   <= DEBP_FMT_W32;
            m_wdata <= '0;
        end else begin
            unique case (mstate)
                DEBP_M_IDLE: if (req_in && tsr_q) begin
                    mstate  <= DEBP_M_ADDR;
                    m_addr  <= req_addr_in;
                    m_write <= req_write_in;
                    m_cond  <= req_cond_in;
                    m_fmt   <= req_fmt_in;
                    m_wdata <= req_wdata_in;
                end
                DEBP_M_ADDR:   mstate <= DEBP_M_STROBE;
                DEBP_M_STROBE: mstate <= DEBP_M_IDLE;
            endcase
        end
    end

    // pins of the master side
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus.dev_addr      <= '0;
            bus.dev_addr_oe   <= 1'b0;
            bus.dev_rd_n      <= 1'b1;
            bus.dev_wr_n      <= 1'b1;
            bus.dev_sw_n      <= 1'b1;
            bus.dev_strobe_oe <= 1'b0;
            bus.dev_ctl_oe    <= 1'b0;
            bus.bank_select_n <= '1;
            bus.page          <= 1'b0;
            last_page         <= '0;
            last_page_ok      <= 1'b0;
        end else begin
            bus.dev_rd_n <= 1'b1;
            bus.dev_wr_n <= 1'b1;
            if (mstate == DEBP_M_IDLE && req_in && tsr_q) begin
                bus.dev_addr      <= req_addr_in; // R1
                bus.dev_addr_oe   <= 1'b1;
                bus.dev_strobe_oe <= 1'b1; // R11
                bus.dev_ctl_oe    <= 1'b1;
                bus.dev_sw_n      <= !req_write_in; // R13 R14
                bus.bank_select_n <= req_sel; // R6 R7
                bus.page          <= !req_sel[0] && page_cross; // R12
                last_page    <= req_addr_in >> (PAGE_BASE + int'(page_size_in));
                last_page_ok <= 1'b1;
            end else if (mstate == DEBP_M_ADDR && tsr_q) begin
                bus.dev_rd_n <= !(!m_write && m_cond); // R9
                bus.dev_wr_n <= !(m_write && m_cond); // R10 R13
                bus.page     <= 1'b0;
            end else begin
                // idle, end of access or bus taken away: release everything
                bus.dev_addr_oe   <= 1'b0; // R16
                bus.dev_strobe_oe <= 1'b0;
                bus.dev_ctl_oe    <= 1'b0;
                bus.dev_sw_n      <= 1'b1;
                bus.bank_select_n <= '1; // R7
                bus.page          <= 1'b0;
            end
        end
    end

    // master busy and done flags and read capture
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out  <= 1'b0;
            busy_out  <= 1'b0;
            rdata_out <= '0;
        end else begin
            busy_out <= drive_en || (mstate == DEBP_M_IDLE && req_in);
            done_out <= (mstate == DEBP_M_STROBE);
            if (mstate == DEBP_M_STROBE && !m_write)
                rdata_out <= debp_unpack(m_fmt, bus.ext_data_bus); // R2 R3 R4 R5
        end
    end

    // ============================================================
    // slave responder with internal memory
    logic [39:0]       mem [MEM_DEPTH];
    logic              s_active;
    logic              s_write;
    logic [MEM_AW-1:0] s_idx;
    logic              wr_seen;
    logic              id_hit;
    logic              wr_hit;
    assign id_hit = slave_mode && (bus.ext_address_bus[ID_LO +: ID_W] == proc_id_in);
    assign wr_hit = id_hit && !wr_q && !wr_seen && !bus.sync_write_select_n;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus.ack         <= 1'b0;
            bus.ack_oe      <= 1'b0;
            s_active        <= 1'b0;
            s_write         <= 1'b0;
            s_idx           <= '0;
            wr_seen         <= 1'b0;
            slave_write_out <= 1'b0;
            slave_index_out <= '0;
        end else begin
            // ack pulses one cycle, regardless of strobes or wait setting
            bus.ack_oe <= id_hit && !bus.ack_oe; // R17 R18
            bus.ack    <= 1'b1;
            s_active   <= id_hit && !rd_q; // R19 R9
            s_write  <= !bus.sync_write_select_n; // R15
            s_idx    <= bus.ext_address_bus[MEM_AW-1:0];
            // one write per strobe: a held strobe is not applied again
            wr_seen  <= !wr_q && (wr_seen || wr_hit);
            slave_write_out <= 1'b0;
            if (wr_hit) begin // R10 R15
                slave_write_out <= 1'b1;
                slave_index_out <= bus.ext_address_bus[MEM_AW-1:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_hit)
            mem[bus.ext_address_bus[MEM_AW-1:0]] <=
                debp_unpack(DEBP_FMT_W40, bus.ext_data_bus); // R3
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus.dev_data    <= '0;
            bus.dev_data_oe <= 1'b0;
        end else if (mstate != DEBP_M_IDLE && m_write && tsr_q) begin
            bus.dev_data    <= debp_pack(m_fmt, m_wdata); // R2 R3 R4 R5
            bus.dev_data_oe <= 1'b1;
        end else if (s_active && !s_write && !rd_q) begin
            bus.dev_data    <= debp_pack(DEBP_FMT_W40, mem[s_idx]); // R19
            bus.dev_data_oe <= 1'b1;
        end else begin
            bus.dev_data_oe <= 1'b0; // R16
        end
    end
    // wait-state setting does not gate the ack path
    logic unused_ws;
    assign unused_ws = mp_space_wait_state_en_in;
endmodule

// ### logic/debp_far.sv
// outside party end: a simple master that reads and writes the device
`timescale 1ns/1ps
module debp_far
    import debp_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    debp_if.far                    bus,
    input  wire logic              tristate_req_in,
    input  wire logic              req_in,
    input  wire logic              req_write_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire debp_pkg::debp_fmt_t req_fmt_in,
    input  wire logic [39:0]       req_wdata_in,
    output logic                   done_out,
    output logic [39:0]            rdata_out
);
    import debp_pkg::*;

    // ============================================================
    // access sequencer
    debp_mstate_t st;
    logic         wr;
    debp_fmt_t    fmt;
    logic [2:0]   cnt;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st                         <= DEBP_M_IDLE;
            wr                         <= 1'b0;
            fmt                        <= DEBP_FMT_W32;
            cnt                        <= '0;
            bus.far_addr               <= '0;
            bus.far_addr_oe            <= 1'b0;
            bus.far_data               <= '0;
            bus.far_data_oe            <= 1'b0;
            bus.far_rd_n               <= 1'b1;
            bus.far_wr_n               <= 1'b1;
            bus.far_sw_n               <= 1'b1;
            bus.far_strobe_oe          <= 1'b0;
            bus.bus_tristate_request_n <= 1'b1;
            done_out                   <= 1'b0;
            rdata_out                  <= '0;
        end else begin
            bus.bus_tristate_request_n <= !tristate_req_in;
            done_out <= 1'b0;
            unique case (st)
                DEBP_M_IDLE: if (req_in) begin
                    st                <= DEBP_M_ADDR;
                    wr                <= req_write_in;
                    fmt               <= req_fmt_in;
                    cnt               <= '0;
                    bus.far_addr      <= req_addr_in;
                    bus.far_addr_oe   <= 1'b1;
                    bus.far_strobe_oe <= 1'b1;
                    bus.far_sw_n      <= !req_write_in; // R15
                    bus.far_rd_n      <= req_write_in; // R9
                    bus.far_wr_n      <= !req_write_in; // R10
                    bus.far_data      <= debp_pack(req_fmt_in, req_wdata_in); // R2 R3 R4 R5
                    bus.far_data_oe   <= req_write_in;
                end
                DEBP_M_ADDR: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'(FAR_HOLD)) st <= DEBP_M_STROBE;
                end
                DEBP_M_STROBE: begin
                    // read data appears late; hold strobes until it is taken
                    st                <= DEBP_M_IDLE;
                    done_out          <= 1'b1;
                    if (!wr) rdata_out <= debp_unpack(fmt, bus.ext_data_bus);
                    bus.far_addr_oe   <= 1'b0;
                    bus.far_data_oe   <= 1'b0;
                    bus.far_strobe_oe <= 1'b0;
                    bus.far_rd_n      <= 1'b1;
                    bus.far_wr_n      <= 1'b1;
                    bus.far_sw_n      <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ### dv/debp_properties.sv
// concurrent checks on the shared external bus wires
`timescale 1ns/1ps
module debp_properties
    import debp_pkg::*;
#(
    parameter logic [ID_W-1:0] OWN_ID = 3'h2
)(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [ADDR_W-1:0] ext_address_bus,
    input  wire logic              dev_addr_oe,
    input  wire logic              dev_data_oe,
    input  wire logic              dev_strobe_oe,
    input  wire logic              dev_rd_n,
    input  wire logic              dev_wr_n,
    input  wire logic              dev_sw_n,
    input  wire logic              far_addr_oe,
    input  wire logic              far_strobe_oe,
    input  wire logic [BANKS-1:0]  bank_select_n,
    input  wire logic              page,
    input  wire logic              ack_oe,
    input  wire logic              bus_tristate_request_n
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ==========================================================
    // transfer phases
    sequence s_wr;
        dev_strobe_oe && !dev_wr_n;
    endsequence
    sequence s_rd;
        dev_strobe_oe && !dev_rd_n;
    endsequence
    sequence s_own;
        far_addr_oe && ext_address_bus[ID_LO+ID_W-1:ID_LO] == OWN_ID;
    endsequence
    // ==========================================================
    // master side
    chk_wr_walk: assert property (s_wr |-> dev_addr_oe && dev_data_oe && !dev_sw_n
        && $past(dev_addr_oe)) else $error("write strobe outside address phase");
    chk_wr_single: assert property (s_wr |=> !(dev_strobe_oe && !dev_wr_n))
        else $error("write strobe longer than one cycle");
    chk_rd_phase: assert property (s_rd |-> dev_addr_oe && dev_sw_n && dev_wr_n
        && !dev_data_oe) else $error("read strobe with bad qualifiers");
    chk_sw_early: assert property ($fell(dev_sw_n) && dev_strobe_oe |-> $rose(dev_addr_oe))
        else $error("sync select not with address");
    chk_sel_idle: assert property (!dev_addr_oe |-> bank_select_n == 4'hf)
        else $error("bank select active while idle");
    chk_sel_onehot: assert property ($countones(~bank_select_n) <= 1)
        else $error("more than one bank select");
    chk_page_bank0: assert property (page && dev_addr_oe |-> !bank_select_n[0])
        else $error("page flag outside bank zero");
    // ==========================================================
    // release and slave side
    chk_slave_quiet: assert property (far_strobe_oe |-> !dev_strobe_oe && !dev_addr_oe)
        else $error("device drives while slave");
    // synchroniser, agreement and output register: released within six cycles
    chk_tristate_off: assert property (!bus_tristate_request_n [*6]
        |-> !dev_addr_oe && !dev_strobe_oe) else $error("drivers kept on tristate");
    chk_ack_single: assert property (ack_oe |=> !ack_oe)
        else $error("ack driven two cycles");
    chk_ack_cause: assert property (ack_oe |-> $past(far_addr_oe
        && ext_address_bus[ID_LO+ID_W-1:ID_LO] == OWN_ID)) else $error("ack without id match");
    chk_ack_follows: assert property ($rose(far_addr_oe) ##0 s_own |-> ##[1:2] ack_oe)
        else $error("ack missing on id match");
endmodule

// ### dv/tb.sv
// self-checking bench: device end and outside party on one bus
`timescale 1ns/1ps
module tb;
    import debp_pkg::*;
    localparam logic [ID_W-1:0] MY_ID = 3'h2;
    logic              clk_in, rst_in, mp_ws, d_req, d_wr, d_cond, f_tri, f_req, f_wr;
    logic              d_done, s_wr, f_done;
    logic [1:0]        bank_size, page_size;
    logic [ADDR_W-1:0] d_addr, f_addr;
    debp_fmt_t         d_fmt, f_fmt;
    logic [39:0]       d_wdata, f_wdata, f_rd;
    logic [MEM_AW-1:0] s_idx;
    logic [47:0]       exp_v;
    logic [47:0]       data_q[$];
    logic [47:0]       idx_q[$];
    int                num_errors, samples_checked, seed, hits;
    debp_if bus();
    debp_device debp_device_inst (.clk_in(clk_in), .rst_in(rst_in), .bus(bus),
        .proc_id_in(MY_ID), .bank_size_in(bank_size), .page_size_in(page_size),
        .mp_space_wait_state_en_in(mp_ws), .req_in(d_req), .req_write_in(d_wr),
        .req_cond_in(d_cond), .req_addr_in(d_addr), .req_fmt_in(d_fmt),
        .req_wdata_in(d_wdata), .busy_out(), .done_out(d_done), .rdata_out(),
        .slave_write_out(s_wr), .slave_index_out(s_idx));
    debp_far debp_far_inst (.clk_in(clk_in), .rst_in(rst_in), .bus(bus),
        .tristate_req_in(f_tri), .req_in(f_req), .req_write_in(f_wr), .req_addr_in(f_addr),
        .req_fmt_in(f_fmt), .req_wdata_in(f_wdata), .done_out(f_done), .rdata_out(f_rd));
    debp_properties #(.OWN_ID(MY_ID)) debp_properties_inst (.clk_in(clk_in),
        .rst_in(rst_in), .ext_address_bus(bus.ext_address_bus),
        .dev_addr_oe(bus.dev_addr_oe), .dev_data_oe(bus.dev_data_oe),
        .dev_strobe_oe(bus.dev_strobe_oe), .dev_rd_n(bus.dev_rd_n), .dev_wr_n(bus.dev_wr_n),
        .dev_sw_n(bus.dev_sw_n), .far_addr_oe(bus.far_addr_oe),
        .far_strobe_oe(bus.far_strobe_oe), .bank_select_n(bus.bank_select_n),
        .page(bus.page), .ack_oe(bus.ack_oe),
        .bus_tristate_request_n(bus.bus_tristate_request_n));
    // ==========================================================
    // helpers
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // a missed handshake ends the run rather than hanging it
    task automatic guard(input logic ok);
        check("handshake", 48'h1, 48'(ok));
        if (ok !== 1'b1) test_done();
    endtask
    function automatic logic [47:0] lanes(input debp_fmt_t f, input logic [39:0] w);
        lanes = '0;
        case (f)
            DEBP_FMT_W32: lanes[47:16] = w[31:0];
            DEBP_FMT_W40: lanes[47:8] = w;
            DEBP_FMT_W16: lanes[31:16] = w[15:0];
            default:      lanes[23:16] = w[7:0];
        endcase
    endfunction
    function automatic logic [BANKS-1:0] exp_sel(input logic [31:0] a);
        logic [31:0] n;
        n = (a - BANK_START) >> (BANK_BASE + bank_size);
        if (a < BANK_START || n > 32'h3) return 4'hf;
        return ~(4'h1 << n[1:0]);
    endfunction
    task automatic dev_op(input logic wr, cond, input logic [31:0] a, input debp_fmt_t f,
                          input logic pg, chk_pg);
        int i;
        {d_req, d_wr, d_cond} = {1'b1, wr, cond};
        d_addr = a;
        d_fmt = f;
        d_wdata = 40'({$random(seed), $random(seed)});
        mp_ws = 1'($random(seed));
        if (wr && cond) data_q.push_back(lanes(f, d_wdata));
        @(negedge clk_in);
        d_req = 1'b0;
        for (i = 0; i < 8 && bus.dev_addr_oe !== 1'b1; i++) @(negedge clk_in);
        guard(bus.dev_addr_oe);
        check("bank select", 48'(exp_sel(a)), 48'(bus.bank_select_n));
        check("sync select", 48'(!wr), 48'(bus.dev_sw_n));
        if (chk_pg) check("page", 48'(pg), 48'(bus.page));
        for (i = 0; i < 8 && bus.dev_addr_oe !== 1'b0; i++) @(negedge clk_in);
        guard(!bus.dev_addr_oe);
        @(negedge clk_in);
    endtask
    task automatic far_op(input logic wr, input logic [ID_W-1:0] id, input debp_fmt_t f);
        int i;
        {f_req, f_wr} = {1'b1, wr};
        // a read revisits the word that the previous write left
        if (wr) f_addr = {9'h0, id, 14'h0, 6'($random(seed))};
        f_fmt = f;
        if (wr) f_wdata = 40'({$random(seed), $random(seed)});
        mp_ws = 1'($random(seed));
        if (wr && id == MY_ID) idx_q.push_back(48'(f_addr[MEM_AW-1:0]));
        @(negedge clk_in);
        f_req = 1'b0;
        for (i = 0; i < 10 && f_done !== 1'b1; i++) @(negedge clk_in);
        guard(f_done);
        if (!wr && id == MY_ID) check("slave read", lanes(f, f_wdata), lanes(f, f_rd));
        // slave answers a few cycles late; let it finish
        repeat (5) @(negedge clk_in);
    endtask
    // ==========================================================
    // result watcher
    always @(negedge clk_in) begin
        if (!rst_in && bus.dev_strobe_oe === 1'b1 && bus.dev_wr_n === 1'b0) begin
            exp_v = data_q.size() > 0 ? data_q.pop_front() : 'x;
            check("write lanes", exp_v, bus.ext_data_bus);
        end
        if (s_wr === 1'b1) begin
            exp_v = idx_q.size() > 0 ? idx_q.pop_front() : 'x;
            check("slave index", exp_v, 48'(s_idx));
        end
    end
    // ==========================================================
    // stimulus
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        seed = 32'h6aa6;
        {rst_in, mp_ws, d_req, d_wr, d_cond, f_tri, f_req, f_wr} = 8'h80;
        {bank_size, page_size, d_addr, f_addr, d_wdata, f_wdata} = '0;
        {d_fmt, f_fmt} = {DEBP_FMT_W32, DEBP_FMT_W32};
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        page_size = 2'h1;
        dev_op(1'b1, 1'b1, BANK_START, DEBP_FMT_W32, 1'b1, 1'b1);
        dev_op(1'b0, 1'b1, BANK_START + 32'h1ff, DEBP_FMT_W32, 1'b0, 1'b1);
        dev_op(1'b1, 1'b1, BANK_START + 32'h200, DEBP_FMT_W40, 1'b1, 1'b1);
        for (int c = 0; c < 4; c++) begin
            bank_size = 2'(c);
            for (int b = 0; b < 4; b++) begin
                d_addr = BANK_START + (32'h1 << (BANK_BASE + c)) * b + 32'($random(seed) & 255);
                dev_op(1'b1, 1'b1, d_addr, debp_fmt_t'(b), 1'b0, 1'b0);
            end
        end
        dev_op(1'b1, 1'b0, 32'h0042_0000, DEBP_FMT_W16, 1'b0, 1'b1);
        dev_op(1'b0, 1'b1, 32'h0043_0004, DEBP_FMT_W32, 1'b0, 1'b1);
        dev_op(1'b1, 1'b1, 32'h0050_0010, DEBP_FMT_W40, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            far_op(1'b1, MY_ID, debp_fmt_t'(k));
            far_op(1'b0, MY_ID, debp_fmt_t'(k));
        end
        far_op(1'b1, 3'h3, DEBP_FMT_W32);
        f_tri = 1'b1;
        repeat (6) @(negedge clk_in);
        {d_req, d_wr, d_cond} = 3'h7;
        @(negedge clk_in);
        d_req = 1'b0;
        hits = 0;
        repeat (8) begin
            @(negedge clk_in);
            if (bus.dev_addr_oe !== 1'b0) hits++;
        end
        check("driver on tristate", 48'h0, 48'(hits));
        f_tri = 1'b0;
        repeat (5) @(negedge clk_in);
        dev_op(1'b1, 1'b1, BANK_START + 32'h40, DEBP_FMT_W8, 1'b0, 1'b0);
        check("queue left", 48'h0, 48'(data_q.size() + idx_q.size()));
        test_done();
    end
endmodule
